// ===== uart_mcls_pkg.sv
// package for the modem control and line status block of one uart channel
// assumes a single 40 MHz clock and a byte-wide register port
package uart_mcls_pkg;

	// --------------------------------
	// register offsets
	// --------------------------------
	localparam logic [3:0] OFF_MODEM_CONTROL = 4'h4;
	localparam logic [3:0] OFF_LINE_STATUS = 4'h5;
	localparam logic [3:0] OFF_INT_STATUS = 4'h8;
	localparam logic [3:0] OFF_INT_MASK = 4'h9;

	// --------------------------------
	// reset values and masks
	// --------------------------------
	localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODEM_CONTROL_WMASK = 8'hbf;
	localparam logic [5:0] INT_RESET = 6'h00;

	// --------------------------------
	// interrupt bit positions
	// --------------------------------
	localparam int INT_OVERRUN = 0;
	localparam int INT_PARITY = 1;
	localparam int INT_FRAMING = 2;
	localparam int INT_BREAK = 3;
	localparam int INT_THR_EMPTY = 4;
	localparam int INT_TSR_EMPTY = 5;
	localparam int INT_BITS = 6;

	// modem_control layout, bit 7 down to bit 0
	typedef struct packed {
		logic half_stop;
		logic rsvd;
		logic auto_flow_enable;
		logic loop;
		logic aux_out_b;
		logic aux_out_a;
		logic rts;
		logic dtr;
	} modem_control_s;

	// line_status layout, bit 7 down to bit 0
	typedef struct packed {
		logic fifo_err;
		logic tsr_empty;
		logic thr_empty;
		logic brk;
		logic framing;
		logic parity;
		logic overrun;
		logic rx_avail;
	} line_flags_s;

	// modem handshake lines, active high meaning asserted
	typedef struct packed {
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_lines_s;

endpackage

// ===== uart_modem_line_ctrl.sv
// modem control and line status registers of one uart channel
// assumes the uart core supplies line flags on CLK and pins arrive asynchronously
// --------------------------------
// --------------------------------
`timescale 1ns/10ps

module uart_modem_line_ctrl import uart_mcls_pkg::*; (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire line_flags_s LINE_FLAGS,
	input wire logic RX_ROOM,
	input wire logic TXD_CORE,
	output logic RXD_CORE,
	output modem_lines_s MODEM_SEEN,
	output logic TX_ALLOW,
	output logic AUTO_RTS_ON,
	output logic AUTO_CTS_ON,
	output logic HALF_STOP,
	output logic IRQ,
	input wire logic RXD,
	input wire logic CTS_N,
	input wire logic DSR_N,
	input wire logic RI_N,
	input wire logic DCD_N,
	output logic TXD,
	output logic DTR_N,
	output logic RTS_N,
	output logic AUX_A_N,
	output logic AUX_B_N
);

	// --------------------------------
	// state
	// --------------------------------
	typedef struct packed {
		modem_control_s modem_control;
		logic [INT_BITS-1:0] int_stat;
		logic [INT_BITS-1:0] int_mask;
		line_flags_s flags_prev;
		logic [7:0] rdata;
		logic [4:0] sync1;
		logic [4:0] sync2;
		modem_lines_s seen;
		logic rxd_core;
		logic txd;
		logic dtr_n;
		logic rts_n;
		logic aux_a_n;
		logic aux_b_n;
	} state_s;

	state_s state;
	state_s next_state;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	logic [INT_BITS-1:0] events;
	logic [INT_BITS-1:0] w1c;
	logic auto_rts;
	logic auto_cts;
	logic diag;
	modem_lines_s pins;

	// --------------------------------
	// combinational next state
	// --------------------------------
	always_comb begin
		next_state = state;
		// sync2 order: rxd, dcd, ri, dsr, cts (inputs active low except rxd)
		next_state.sync1 = {RXD, DCD_N, RI_N, DSR_N, CTS_N};
		next_state.sync2 = state.sync1;
		pins.cts = ~state.sync2[0];
		pins.dsr = ~state.sync2[1];
		pins.ri = ~state.sync2[2];
		pins.dcd = ~state.sync2[3];

		// write of modem_control, reserved bit 6 stays zero
		if (WR && hit(ADDR, OFF_MODEM_CONTROL)) begin
			next_state.modem_control = modem_control_s'(WDATA & MODEM_CONTROL_WMASK);
		end
		if (WR && hit(ADDR, OFF_INT_MASK)) begin
			next_state.int_mask = WDATA[INT_BITS-1:0];
		end

		auto_cts = state.modem_control.auto_flow_enable;
		auto_rts = state.modem_control.auto_flow_enable & state.modem_control.rts;
		diag = ~state.modem_control.auto_flow_enable;

		// rising edges of the core flags except rx_avail and fifo_err are the interrupt events
		next_state.flags_prev = LINE_FLAGS;
		events[INT_OVERRUN] = LINE_FLAGS.overrun & ~state.flags_prev.overrun;
		events[INT_PARITY] = LINE_FLAGS.parity & ~state.flags_prev.parity;
		events[INT_FRAMING] = LINE_FLAGS.framing & ~state.flags_prev.framing;
		events[INT_BREAK] = LINE_FLAGS.brk & ~state.flags_prev.brk;
		events[INT_THR_EMPTY] = LINE_FLAGS.thr_empty & ~state.flags_prev.thr_empty;
		events[INT_TSR_EMPTY] = LINE_FLAGS.tsr_empty & ~state.flags_prev.tsr_empty;
		w1c = (WR && hit(ADDR, OFF_INT_STATUS)) ? WDATA[INT_BITS-1:0] : INT_RESET;
		// a new event beats a clear in the same cycle
		next_state.int_stat = (state.int_stat & ~w1c) | events;

		// read data stands only in the cycle after the strobe
		next_state.rdata = 8'h00;
		if (RD) begin
			if (hit(ADDR, OFF_MODEM_CONTROL)) begin
				next_state.rdata = state.modem_control;
			end else if (hit(ADDR, OFF_LINE_STATUS)) begin
				next_state.rdata = LINE_FLAGS;
			end else if (hit(ADDR, OFF_INT_STATUS)) begin
				next_state.rdata = {2'h0, state.int_stat};
			end else if (hit(ADDR, OFF_INT_MASK)) begin
				next_state.rdata = {2'h0, state.int_mask};
			end
		end

		// loopback routes the control bits to the modem inputs
		if (state.modem_control.loop) begin
			next_state.seen.cts = state.modem_control.rts;
			next_state.seen.dsr = state.modem_control.dtr;
			next_state.seen.ri = state.modem_control.aux_out_a;
			next_state.seen.dcd = state.modem_control.aux_out_b;
		end else begin
			next_state.seen = pins;
		end

		// transmit data comes back to the receiver in loopback or diagnostic mode
		if (state.modem_control.loop || diag) begin
			next_state.rxd_core = TXD_CORE;
		end else begin
			next_state.rxd_core = state.sync2[4];
		end

		// pins are held inactive in loopback so the far end sees an idle line
		if (state.modem_control.loop) begin
			next_state.txd = 1'b1;
			next_state.dtr_n = 1'b1;
			next_state.rts_n = 1'b1;
			next_state.aux_a_n = 1'b1;
			next_state.aux_b_n = 1'b1;
		end else begin
			next_state.txd = TXD_CORE;
			next_state.dtr_n = ~state.modem_control.dtr;
			// auto rts asserts only while the receive side has room
			next_state.rts_n = auto_rts ? ~RX_ROOM : ~state.modem_control.rts;
			next_state.aux_a_n = ~state.modem_control.aux_out_a;
			next_state.aux_b_n = ~state.modem_control.aux_out_b;
		end

		if (RST) begin
			next_state.modem_control = modem_control_s'(MODEM_CONTROL_RESET);
			next_state.int_stat = INT_RESET;
			next_state.int_mask = INT_RESET;
			next_state.flags_prev = '0;
			next_state.rdata = 8'h00;
			next_state.seen = '0;
			next_state.rxd_core = 1'b1;
			next_state.txd = 1'b1;
			next_state.dtr_n = 1'b1;
			next_state.rts_n = 1'b1;
			next_state.aux_a_n = 1'b1;
			next_state.aux_b_n = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		state <= next_state;
	end

	// --------------------------------
	// outputs
	// --------------------------------
	assign RDATA = state.rdata;
	assign RXD_CORE = state.rxd_core;
	assign MODEM_SEEN = state.seen;
	assign AUTO_RTS_ON = auto_rts;
	assign AUTO_CTS_ON = auto_cts;
	// auto cts stalls the transmitter while the far end withholds cts
	assign TX_ALLOW = ~auto_cts | state.seen.cts;
	assign HALF_STOP = state.modem_control.half_stop;
	assign IRQ = |(state.int_stat & state.int_mask);
	assign TXD = state.txd;
	assign DTR_N = state.dtr_n;
	assign RTS_N = state.rts_n;
	assign AUX_A_N = state.aux_a_n;
	assign AUX_B_N = state.aux_b_n;

	// --------------------------------
	// assertions
	// --------------------------------
	a_dtr_level: assert property (@(posedge CLK) disable iff (RST)
		!state.modem_control.loop ##1 !$past(state.modem_control.loop) |-> DTR_N == !$past(state.modem_control.dtr))
		else $error("dtr pin does not follow control bit");

	a_rts_manual: assert property (@(posedge CLK) disable iff (RST)
		(!state.modem_control.loop && !auto_rts) |=> RTS_N == !$past(state.modem_control.rts))
		else $error("rts pin does not follow control bit");

	a_loop_ri: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop |=> MODEM_SEEN.ri == $past(state.modem_control.aux_out_a))
		else $error("ring indicator not looped from aux a");

	a_loop_dcd: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop |=> MODEM_SEEN.dcd == $past(state.modem_control.aux_out_b))
		else $error("carrier detect not looped from aux b");

	a_loop_enable: assert property (@(posedge CLK) disable iff (RST)
		(WR && ADDR == OFF_MODEM_CONTROL) |=> state.modem_control.loop == $past(WDATA[4]))
		else $error("loopback bit not written");

	a_diag_echo: assert property (@(posedge CLK) disable iff (RST)
		!state.modem_control.auto_flow_enable |=> RXD_CORE == $past(TXD_CORE))
		else $error("diagnostic mode does not echo transmit data");

	a_auto_both: assert property (@(posedge CLK) disable iff (RST)
		(state.modem_control.auto_flow_enable && state.modem_control.rts) |-> (AUTO_RTS_ON && AUTO_CTS_ON))
		else $error("auto rts and cts not both on");

	a_auto_cts_only: assert property (@(posedge CLK) disable iff (RST)
		(state.modem_control.auto_flow_enable && !state.modem_control.rts) |-> (!AUTO_RTS_ON && AUTO_CTS_ON))
		else $error("auto cts only mode wrong");

	a_auto_off: assert property (@(posedge CLK) disable iff (RST)
		!state.modem_control.auto_flow_enable |-> (!AUTO_RTS_ON && !AUTO_CTS_ON && TX_ALLOW))
		else $error("automatic flow control not off");

	a_half_stop: assert property (@(posedge CLK) disable iff (RST)
		(WR && ADDR == OFF_MODEM_CONTROL) |=> HALF_STOP == $past(WDATA[7]))
		else $error("half stop output does not follow bit 7");

	a_lsr_read: assert property (@(posedge CLK) disable iff (RST)
		(RD && ADDR == OFF_LINE_STATUS) |=> RDATA == $past(LINE_FLAGS))
		else $error("line status read does not return flags");

	a_loop_pins: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop [*2] |-> (TXD && DTR_N && RTS_N))
		else $error("pins not held inactive in loopback");

	a_irq_level: assert property (@(posedge CLK) disable iff (RST)
		IRQ == |(state.int_stat & state.int_mask))
		else $error("interrupt output disagrees with status");

	// --------------------------------
	// loopback and pin routing checks
	// --------------------------------
	a_loop_cts: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop |=> MODEM_SEEN.cts == $past(state.modem_control.rts))
		else $error("clear to send not looped from rts bit");

	a_loop_dsr: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop |=> MODEM_SEEN.dsr == $past(state.modem_control.dtr))
		else $error("data set ready not looped from dtr bit");

	a_loop_echo: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop |=> RXD_CORE == $past(TXD_CORE))
		else $error("loopback does not return transmit data");

	a_txd_pass: assert property (@(posedge CLK) disable iff (RST)
		!state.modem_control.loop |=> TXD == $past(TXD_CORE))
		else $error("transmit pin does not follow core data");

	a_aux_a_pin: assert property (@(posedge CLK) disable iff (RST)
		!state.modem_control.loop |=> AUX_A_N == !$past(state.modem_control.aux_out_a))
		else $error("aux a pin does not follow control bit");

	a_aux_b_pin: assert property (@(posedge CLK) disable iff (RST)
		!state.modem_control.loop |=> AUX_B_N == !$past(state.modem_control.aux_out_b))
		else $error("aux b pin does not follow control bit");

	// --------------------------------
	// flow control and register checks
	// --------------------------------
	a_auto_rts_room: assert property (@(posedge CLK) disable iff (RST)
		(!state.modem_control.loop && auto_rts) |=> RTS_N == !$past(RX_ROOM))
		else $error("auto rts does not follow receive room");

	a_cts_stall: assert property (@(posedge CLK) disable iff (RST)
		(AUTO_CTS_ON && !MODEM_SEEN.cts) |-> !TX_ALLOW)
		else $error("transmitter allowed while cts withheld");

	a_cts_pass: assert property (@(posedge CLK) disable iff (RST)
		(AUTO_CTS_ON && MODEM_SEEN.cts) |-> TX_ALLOW)
		else $error("transmitter stalled while cts given");

	a_mcr_read: assert property (@(posedge CLK) disable iff (RST)
		(RD && ADDR == OFF_MODEM_CONTROL) |=> RDATA == $past(state.modem_control))
		else $error("modem control read does not return register");

	a_mcr_hold: assert property (@(posedge CLK) disable iff (RST)
		!(WR && ADDR == OFF_MODEM_CONTROL) |=> $stable(state.modem_control))
		else $error("modem control changed without a write");

	a_rsvd_zero: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.rsvd == 1'b0)
		else $error("reserved control bit set");

	a_rdata_idle: assert property (@(posedge CLK) disable iff (RST)
		!RD |=> RDATA == 8'h00)
		else $error("read data stands without a read");

	a_int_clear: assert property (@(posedge CLK) disable iff (RST)
		(WR && ADDR == OFF_INT_STATUS && WDATA[0] && !events[0]) |=> !state.int_stat[0])
		else $error("interrupt status bit not cleared by write");

	a_rts_loop: assert property (@(posedge CLK) disable iff (RST)
		state.modem_control.loop |=> (RTS_N && AUX_A_N && AUX_B_N))
		else $error("control pins not idle in loopback");

	generate
		for (genvar i = 0; i < INT_BITS; i++) begin : g_sticky
			a_sticky_set: assert property (@(posedge CLK) disable iff (RST)
				events[i] |=> state.int_stat[i])
				else $error("event lost from interrupt status");
		end
	endgenerate

	c_loopback: cover property (@(posedge CLK) disable iff (RST) $rose(state.modem_control.loop));
	c_auto_flow: cover property (@(posedge CLK) disable iff (RST) AUTO_RTS_ON && !RX_ROOM);
	c_irq: cover property (@(posedge CLK) disable iff (RST) $rose(IRQ));
	c_lsr_read: cover property (@(posedge CLK) disable iff (RST) RD && ADDR == OFF_LINE_STATUS);
	c_loop_echo: cover property (@(posedge CLK) disable iff (RST) state.modem_control.loop && !TXD_CORE);

endmodule // uart_modem_line_ctrl

// ===== uart_modem_far.sv
// far-side modem model: answers the handshake pins of one uart channel
// assumes the bench steers its clear-to-send, ring, carrier and line levels
`timescale 1ns/10ps

module uart_modem_far (
	input wire logic TXD,
	input wire logic DTR_N,
	input wire logic RTS_N,
	input wire logic CTS_GIVE,
	input wire logic RING,
	input wire logic CARRIER,
	input wire logic LINE_LVL,
	output logic CTS_N,
	output logic DSR_N,
	output logic RI_N,
	output logic DCD_N,
	output logic RXD
);
	// --------------------------------
	// pin answers
	// --------------------------------
	// a modem reports ready only while the terminal holds its ready line
	assign DSR_N = DTR_N;
	assign CTS_N = !CTS_GIVE;
	assign RI_N = !RING;
	assign DCD_N = !CARRIER;
	assign RXD = LINE_LVL;
endmodule // uart_modem_far

// ===== test_uart_modem_ctrl_line_status.sv
// bench for the modem control and line status block
// assumes the far-side modem model and a 40 MHz clock
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_uart_modem_ctrl_line_status import uart_mcls_pkg::*;;
	logic CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, RX_ROOM = 1'b1, TXD_CORE = 1'b1;
	logic [3:0] ADDR = 4'h0;
	logic [7:0] WDATA = 8'h00, RDATA, rd_val;
	line_flags_s LINE_FLAGS = '0;
	modem_lines_s MODEM_SEEN;
	logic RXD_CORE, TX_ALLOW, AUTO_RTS_ON, AUTO_CTS_ON, HALF_STOP, IRQ, TXD, DTR_N, RTS_N, AUX_A_N, AUX_B_N;
	logic RXD, CTS_N, DSR_N, RI_N, DCD_N;
	logic cts_give = 1'b1, ring = 1'b0, carrier = 1'b0, line_lvl = 1'b1;
	int error_cnt = 0, num_checks = 0;

	always #12.5 CLK = !CLK;

	uart_modem_line_ctrl dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .LINE_FLAGS(LINE_FLAGS), .RX_ROOM(RX_ROOM), .TXD_CORE(TXD_CORE),
		.RXD_CORE(RXD_CORE), .MODEM_SEEN(MODEM_SEEN), .TX_ALLOW(TX_ALLOW), .AUTO_RTS_ON(AUTO_RTS_ON),
		.AUTO_CTS_ON(AUTO_CTS_ON), .HALF_STOP(HALF_STOP), .IRQ(IRQ), .RXD(RXD), .CTS_N(CTS_N),
		.DSR_N(DSR_N), .RI_N(RI_N), .DCD_N(DCD_N), .TXD(TXD), .DTR_N(DTR_N), .RTS_N(RTS_N),
		.AUX_A_N(AUX_A_N), .AUX_B_N(AUX_B_N));

	uart_modem_far far (.TXD(TXD), .DTR_N(DTR_N), .RTS_N(RTS_N), .CTS_GIVE(cts_give), .RING(ring),
		.CARRIER(carrier), .LINE_LVL(line_lvl), .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N),
		.DCD_N(DCD_N), .RXD(RXD));

	// --------------------------------
	// bus and timing helpers
	// --------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK);
		WR <= 1'b1; ADDR <= a; WDATA <= d;
		@(posedge CLK);
		WR <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge CLK);
		RD <= 1'b1; ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		rd_val = RDATA;
	endtask

	// pin paths take up to three edges through the synchronisers
	// outputs are looked at mid-cycle, clear of the edge that launches them
	task automatic settle(input int n);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
	endtask

	task automatic complete_run;
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_reset_and_pins;
		rd(OFF_MODEM_CONTROL);
		`CHK(rd_val, MODEM_CONTROL_RESET)
		`CHK({DTR_N, RTS_N, AUX_A_N, AUX_B_N}, 4'hf)
		@(posedge CLK);
		TXD_CORE <= 1'b0;
		settle(3);
		`CHK(RXD_CORE, 1'b0)
		@(posedge CLK);
		TXD_CORE <= 1'b1;
		wr(OFF_MODEM_CONTROL, 8'h01);
		settle(2);
		`CHK({DTR_N, RTS_N}, 2'b01)
		wr(OFF_MODEM_CONTROL, 8'h0e);
		settle(2);
		`CHK({DTR_N, RTS_N, AUX_A_N, AUX_B_N}, 4'h8)
		wr(OFF_MODEM_CONTROL, 8'hc0);
		rd(OFF_MODEM_CONTROL);
		`CHK(rd_val, 8'h80)
		`CHK(HALF_STOP, 1'b1)
		wr(OFF_MODEM_CONTROL, 8'h00);
		settle(2);
		`CHK(HALF_STOP, 1'b0)
	endtask

	task automatic t_loopback;
		@(posedge CLK);
		ring <= 1'b0;
		carrier <= 1'b0;
		cts_give <= 1'b1;
		wr(OFF_MODEM_CONTROL, 8'h1f);
		settle(4);
		`CHK({TXD, DTR_N, RTS_N, AUX_A_N, AUX_B_N}, 5'h1f)
		`CHK(MODEM_SEEN, 4'hf)
		@(posedge CLK);
		TXD_CORE <= 1'b0;
		settle(3);
		`CHK(RXD_CORE, 1'b0)
		`CHK(TXD, 1'b1)
		wr(OFF_MODEM_CONTROL, 8'h10);
		settle(4);
		`CHK(MODEM_SEEN, 4'h0)
		// loopback with auto flow set: the echo can only come from loopback
		wr(OFF_MODEM_CONTROL, 8'h30);
		settle(3);
		`CHK(RXD_CORE, 1'b0)
		@(posedge CLK);
		TXD_CORE <= 1'b1;
		wr(OFF_MODEM_CONTROL, 8'h00);
		settle(4);
		`CHK(MODEM_SEEN.cts, 1'b1)
		@(posedge CLK);
		ring <= 1'b1;
		carrier <= 1'b1;
		settle(4);
		`CHK(MODEM_SEEN, 4'hd)
		@(posedge CLK);
		ring <= 1'b0;
		carrier <= 1'b0;
	endtask

	task automatic t_flow;
		wr(OFF_MODEM_CONTROL, 8'h22);
		settle(2);
		`CHK({AUTO_RTS_ON, AUTO_CTS_ON}, 2'b11)
		@(posedge CLK);
		RX_ROOM <= 1'b0;
		settle(2);
		`CHK(RTS_N, 1'b1)
		@(posedge CLK);
		RX_ROOM <= 1'b1;
		settle(2);
		`CHK(RTS_N, 1'b0)
		@(posedge CLK);
		cts_give <= 1'b0;
		settle(4);
		`CHK(TX_ALLOW, 1'b0)
		@(posedge CLK);
		line_lvl <= 1'b0;
		TXD_CORE <= 1'b0;
		settle(4);
		`CHK(RXD_CORE, 1'b0)
		@(posedge CLK);
		line_lvl <= 1'b1;
		settle(4);
		`CHK(RXD_CORE, 1'b1)
		`CHK(TXD, 1'b0)
		wr(OFF_MODEM_CONTROL, 8'h20);
		settle(2);
		`CHK({AUTO_RTS_ON, AUTO_CTS_ON, TX_ALLOW}, 3'b010)
		@(posedge CLK);
		cts_give <= 1'b1;
		settle(4);
		`CHK(TX_ALLOW, 1'b1)
		@(posedge CLK);
		cts_give <= 1'b0;
		wr(OFF_MODEM_CONTROL, 8'h02);
		settle(4);
		`CHK({AUTO_RTS_ON, AUTO_CTS_ON, TX_ALLOW}, 3'b001)
		`CHK(RXD_CORE, 1'b0)
		@(posedge CLK);
		TXD_CORE <= 1'b1;
		cts_give <= 1'b1;
		wr(OFF_MODEM_CONTROL, 8'h00);
	endtask

	task automatic t_status;
		for (int i = 0; i < 8; i++) begin
			@(posedge CLK);
			LINE_FLAGS <= line_flags_s'(8'h01 << i);
			rd(OFF_LINE_STATUS);
			`CHK(rd_val, 8'h01 << i)
		end
		wr(OFF_LINE_STATUS, 8'hff);
		rd(OFF_LINE_STATUS);
		`CHK(rd_val, 8'h80)
		rd(4'h3);
		`CHK(rd_val, 8'h00)
		@(posedge CLK);
		LINE_FLAGS <= '0;
		wr(OFF_INT_STATUS, 8'h3f);
	endtask

	task automatic t_irq;
		wr(OFF_INT_MASK, 8'h01);
		LINE_FLAGS <= line_flags_s'(8'h08);
		settle(3);
		`CHK(IRQ, 1'b0)
		rd(OFF_INT_STATUS);
		`CHK(rd_val, 8'h04)
		@(posedge CLK);
		LINE_FLAGS <= line_flags_s'(8'h0a);
		settle(3);
		`CHK(IRQ, 1'b1)
		wr(OFF_INT_STATUS, 8'h01);
		settle(1);
		`CHK(IRQ, 1'b0)
		rd(OFF_INT_STATUS);
		`CHK(rd_val, 8'h04)
		@(posedge CLK);
		LINE_FLAGS <= '0;
		wr(OFF_INT_STATUS, 8'h3f);
		rd(OFF_INT_STATUS);
		`CHK(rd_val, 8'h00)
	endtask

	// --------------------------------
	// main sequence and watchdog
	// --------------------------------
	initial begin
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		t_reset_and_pins();
		t_loopback();
		t_flow();
		t_status();
		t_irq();
		complete_run();
	end

	initial begin
		repeat (4000) @(posedge CLK);
		error_cnt++;
		complete_run();
	end
endmodule // test_uart_modem_ctrl_line_status
